//--- multi_line_async_serial_mux.sv
// multi_line_async_serial_mux: eight-line async multiplexer with scanner, shared receive queue, register port
// assumes bus master and interrupt acknowledge run on core_clk; serial and strap pins are asynchronous
// Operation
// - receive done event per new queue head
// - alarm after sixteen chars enter queue
// - alarm stays quiet until queue is read
// - alarm mode mutes receive done event
// - transmit ready event when scanner finds line
// - modem inputs never interrupt
// - interrupt level five, strap picks four/six/seven
// - one rate per line, both directions
// - receiver enable per line
// - scanner visits each line in turn
// - one shared sixty-four entry queue
// - scanner paced by 5.068 MHz, four phases
// - four addresses give six registers
// - two addresses differ for read, write
// - some registers byte writable, others word only
// - decode base switches, strobe chosen register
// - hold interrupt request until acknowledged
// - independent receiver-transmitter for each line
// - five to eight data bits
// - one start, one/two stops, one and a half for five
// - least significant bit first
// - send and detect break per line
`timescale 1ns/1ps
module multi_line_async_serial_mux
   import serial_mux_pkg::*;
#(
   parameter int unsigned core_hz = CORE_CLK_HZ
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [5:0]       bus_addr,
   input  wire logic [15:0]      bus_wdata,
   input  wire logic [1:0]       bus_bytes,
   input  wire logic             bus_wr,
   input  wire logic             bus_rd,
   output      logic [15:0]      bus_rdata,
   input  wire logic [3:0]       base_switch,
   input  wire logic [1:0]       level_switch,
   input  wire logic             irq_ack,
   output      logic             irq_req,
   output      logic             irq_src,
   output      logic [2:0]       irq_level,
   input  wire logic [LINES-1:0] rxd,
   output      logic [LINES-1:0] txd,
   input  wire logic [LINES-1:0] carrier,
   input  wire logic [LINES-1:0] ring
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [LINES-1:0]       rxd_m, rxd_s, car_m, car_s, ring_m, ring_s;
      logic [3:0]             base_m, base_s;
      logic [1:0]             lvl_m, lvl_s;
      logic [2:0]             irq_level;
      logic [31:0]            osc_acc;
      logic [1:0]             phase;
      logic [LINE_W-1:0]      line;
      scan_state_t            scan;
      logic                   scan_en, rx_ie, tx_ie, alarm_mode, alarm, armed;
      logic [4:0]             since;
      logic [LINES-1:0]       tx_en, brk;
      logic [FIFO_AW-1:0]     wr_ptr, rd_ptr;
      logic [FIFO_AW:0]       cnt;
      logic                   rx_pend, tx_pend, irq_req, irq_src;
      logic [15:0]            rdata;
      logic [LINES-1:0][16:0] baud_cnt;
      logic [LINES-1:0][1:0]  len, stop;
      logic [LINES-1:0][3:0]  rate;
      logic [LINES-1:0]       rx_en, rx_busy, hold_full, hold_brk, hold_ferr, tx_busy, tx_full, txd;
      logic [LINES-1:0][7:0]  rx_tick, rx_data, hold, tx_tick, tx_buf, tx_char;
   } mux_state_t;

   mux_state_t         st;
   mux_state_t         n;
   logic [ENTRY_W-1:0] head;
   logic [ENTRY_W-1:0] entry;
   logic [32:0]        osc_sum;
   logic               osc_tick;
   logic               hit;
   logic [1:0]         idx;
   logic               wr_ok;
   logic               rd_ok;
   logic               word;
   logic               push;
   logic               pop;
   logic               rearm;
   logic               alarm_fire;
   logic               head_event;
   logic               halt_entry;
   logic               tx_wr;
   logic               os;
   logic [3:0]         nbits;
   logic [7:0]         frame;
   logic [LINES-1:0]   rx_fin;

   // ==========================================================
   // helpers
   function automatic logic [3:0] data_bits(input logic [1:0] len_code);
      data_bits = 4'h5 + {2'h0, len_code};
   endfunction

   function automatic logic [16:0] rate_div(input logic [3:0] sel);
      rate_div = 17'((64'(core_hz) * 64'd10) / (64'(OS_RATE) * 64'(BAUD_X10[sel])));
   endfunction

   function automatic logic [7:0] stop_ticks(input logic [1:0] code, input logic [1:0] len_code);
      if (code == STOP_TWO) begin
         stop_ticks = TICK_STOP_TWO;
      end else if (code == STOP_HALF && len_code == 2'h0) begin
         stop_ticks = TICK_STOP_HALF;
      end else begin
         stop_ticks = TICK_BIT;
      end
   endfunction

   rx_fifo_store u_store (
      .clk     (core_clk),
      .rst     (rst),
      .wr_en   (push),
      .wr_addr (st.wr_ptr),
      .wr_data (entry),
      .rd_addr (n.rd_ptr),
      .rd_data (head)
   );

   // ==========================================================
   // next state
   always_comb begin
      n          = st;
      os         = 1'b0;
      nbits      = 4'h0;
      frame      = 8'h0;
      rx_fin     = '0;
      push       = 1'b0;
      entry      = '0;
      halt_entry = 1'b0;
      tx_wr      = 1'b0;

      // pins and straps cross in through two flops
      n.rxd_m  = rxd;
      n.rxd_s  = st.rxd_m;
      n.car_m  = carrier;
      n.car_s  = st.car_m;
      n.ring_m = ring;
      n.ring_s = st.ring_m;
      n.base_m = base_switch;
      n.base_s = st.base_m;
      n.lvl_m  = level_switch;
      n.lvl_s  = st.lvl_m;
      n.irq_level = LEVEL_BY_SEL[st.lvl_s];

      osc_sum  = {1'b0, st.osc_acc} + 33'(OSC_HZ);
      osc_tick = osc_sum >= 33'(core_hz);
      n.osc_acc = osc_tick ? 32'(osc_sum - 33'(core_hz)) : osc_sum[31:0];
      if (osc_tick) begin
         n.phase = st.phase + 2'h1;
      end

      hit   = st.base_s == bus_addr[5:2];
      idx   = bus_addr[1:0];
      wr_ok = bus_wr && hit;
      rd_ok = bus_rd && hit;
      word  = bus_bytes == 2'h3;
      pop   = rd_ok && (idx == ADDR_RXBUF) && (st.cnt != '0);
      rearm = rd_ok && (idx == ADDR_RXBUF);

      for (int i = 0; i < LINES; i++) begin
         nbits = data_bits(st.len[i]);
         os    = st.baud_cnt[i] == 17'h0;
         n.baud_cnt[i] = os ? rate_div(st.rate[i]) - 17'h1 : st.baud_cnt[i] - 17'h1;
         if (!st.rx_busy[i]) begin
            if (st.rx_en[i] && os && !st.rxd_s[i]) begin
               n.rx_busy[i] = 1'b1;
               n.rx_tick[i] = 8'h0;
            end
         end else if (os) begin
            n.rx_tick[i] = st.rx_tick[i] + 8'h1;
            if (st.rx_tick[i][3:0] == TICK_MID) begin
               if (st.rx_tick[i][7:4] == 4'h0) begin
                  // a start bit gone by mid-bit was noise
                  n.rx_busy[i] = !st.rxd_s[i];
               end else if (st.rx_tick[i][7:4] <= nbits) begin
                  n.rx_data[i] = {st.rxd_s[i], st.rx_data[i][7:1]};
               end else begin
                  n.rx_busy[i]   = 1'b0;
                  rx_fin[i]      = 1'b1;
                  n.hold[i]      = st.rx_data[i] >> (4'h8 - nbits);
                  n.hold_full[i] = 1'b1;
                  n.hold_ferr[i] = !st.rxd_s[i];
                  n.hold_brk[i]  = !st.rxd_s[i] && (n.hold[i] == 8'h0);
               end
            end
         end
         frame = {nbits, 4'h0} + TICK_BIT + stop_ticks(st.stop[i], st.len[i]);
         if (!st.tx_busy[i]) begin
            if (st.tx_full[i]) begin
               n.tx_busy[i] = 1'b1;
               n.tx_tick[i] = 8'h0;
               n.tx_char[i] = st.tx_buf[i];
               n.tx_full[i] = 1'b0;
            end
         end else if (os) begin
            n.tx_tick[i] = st.tx_tick[i] + 8'h1;
            if (n.tx_tick[i] == frame) begin
               n.tx_busy[i] = 1'b0;
            end
         end
         // break holds the line at space
         if (st.brk[i]) begin
            n.txd[i] = 1'b0;
         end else if (!n.tx_busy[i]) begin
            n.txd[i] = 1'b1;
         end else if (n.tx_tick[i][7:4] == 4'h0) begin
            n.txd[i] = 1'b0;
         end else if (n.tx_tick[i][7:4] <= nbits) begin
            n.txd[i] = n.tx_char[i][3'(n.tx_tick[i][7:4] - 4'h1)];
         end else begin
            n.txd[i] = 1'b1;
         end
      end

      unique case (st.scan)
         SCAN_IDLE: begin
            if (st.scan_en) begin
               n.scan = SCAN_RUN;
            end
         end
         SCAN_RUN: begin
            if (!st.scan_en) begin
               n.scan = SCAN_IDLE;
            end else if (osc_tick && st.phase == PHASE_RX && st.hold_full[st.line]) begin
               // tag with line; a full queue drops the char
               push  = st.cnt != 7'(FIFO_DEPTH);
               entry = {st.hold_brk[st.line], st.hold_ferr[st.line], st.line, st.hold[st.line]};
               if (!rx_fin[st.line]) begin
                  n.hold_full[st.line] = 1'b0;
               end
            end else if (osc_tick && st.phase == PHASE_TX && st.tx_en[st.line] && !st.tx_full[st.line]) begin
               n.scan     = SCAN_HALT;
               halt_entry = 1'b1;
            end else if (osc_tick && st.phase == PHASE_STEP) begin
               n.line = st.line + 3'h1;
            end
         end
         SCAN_HALT: begin
            if (wr_ok && idx == ADDR_MODEM && bus_bytes[0]) begin
               tx_wr                = 1'b1;
               n.tx_buf[st.line]    = bus_wdata[7:0];
               n.tx_full[st.line]   = 1'b1;
               n.scan               = SCAN_RUN;
            end else if (!st.tx_en[st.line] || !st.scan_en) begin
               n.scan = SCAN_RUN;
            end
         end
         default: begin
            n.scan = SCAN_IDLE;
         end
      endcase

      // queue pointers
      if (push) begin
         n.wr_ptr = st.wr_ptr + 6'h1;
      end
      if (pop) begin
         n.rd_ptr = st.rd_ptr + 6'h1;
      end
      n.cnt = st.cnt + 7'(push) - 7'(pop);
      // a new char reached the head
      head_event = (n.cnt != '0) && ((st.cnt == '0) || pop);

      alarm_fire = push && st.armed && (st.since == ALARM_LEVEL - 5'h1);
      if (push && st.armed) begin
         n.since = st.since + 5'h1;
      end
      // a read re-arms, a firing wins over it
      if (alarm_fire) begin
         n.alarm = 1'b1;
         n.armed = 1'b0;
      end else if (rearm) begin
         n.alarm = 1'b0;
         n.armed = 1'b1;
         n.since = 5'h0;
      end

      if (irq_ack && st.irq_req) begin
         if (st.irq_src == SRC_RX) begin
            n.rx_pend = 1'b0;
         end else begin
            n.tx_pend = 1'b0;
         end
      end
      // alarm mode replaces the per-char event
      if (st.rx_ie && (st.alarm_mode ? alarm_fire : head_event)) begin
         n.rx_pend = 1'b1;
      end
      if (st.tx_ie && halt_entry) begin
         n.tx_pend = 1'b1;
      end
      // modem changes have no path here
      n.irq_req = n.rx_pend || n.tx_pend;
      n.irq_src = n.rx_pend ? SRC_RX : SRC_TX;

      if (wr_ok) begin
         unique case (idx)
            ADDR_CTRL: begin
               if (bus_bytes[0]) begin
                  n.scan_en = bus_wdata[CTRL_SCAN_EN];
                  n.rx_ie   = bus_wdata[CTRL_RX_IE];
               end
               if (bus_bytes[1]) begin
                  n.alarm_mode = bus_wdata[CTRL_ALARM_MODE];
                  n.tx_ie      = bus_wdata[CTRL_TX_IE];
               end
            end
            ADDR_RXBUF: begin
               // write side is line setup, word only
               if (word) begin
                  n.len[bus_wdata[PRM_LINE_LO +: 3]]   = bus_wdata[PRM_LEN_LO +: 2];
                  n.stop[bus_wdata[PRM_LINE_LO +: 3]]  = bus_wdata[PRM_STOP_LO +: 2];
                  n.rate[bus_wdata[PRM_LINE_LO +: 3]]  = bus_wdata[PRM_RATE_LO +: 4];
                  n.rx_en[bus_wdata[PRM_LINE_LO +: 3]] = bus_wdata[PRM_RX_EN];
               end
            end
            ADDR_TXCTRL: begin
               if (bus_bytes[0]) begin
                  n.tx_en = bus_wdata[7:0];
               end
               if (bus_bytes[1]) begin
                  n.brk = bus_wdata[15:8];
               end
            end
            ADDR_MODEM: begin
               // transmit data is taken by the scanner while halted
            end
         endcase
      end

      // read side of the shared addresses
      n.rdata = 16'h0;
      if (rd_ok) begin
         unique case (idx)
            ADDR_CTRL: begin
               n.rdata = {st.scan == SCAN_HALT, st.tx_ie, st.alarm, st.alarm_mode, 1'b0, st.line,
                          st.cnt != '0, st.rx_ie, st.scan_en, 5'h0};
            end
            ADDR_RXBUF: begin
               n.rdata = {st.cnt != '0, head[12:11], 2'h0, head[10:0]};
            end
            ADDR_TXCTRL: begin
               n.rdata = {st.brk, st.tx_en};
            end
            ADDR_MODEM: begin
               n.rdata = {st.car_s, st.ring_s};
            end
         endcase
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st           <= '0;
         st.scan      <= SCAN_IDLE;
         st.armed     <= 1'b1;
         st.irq_level <= LEVEL_DEFAULT;
         st.rxd_m     <= '1;
         st.rxd_s     <= '1;
         st.txd       <= '1;
         st.len       <= {LINES{LEN_RESET}};
         st.rate      <= {LINES{RATE_RESET}};
         st.stop      <= {LINES{STOP_ONE}};
      end else begin
         st <= n;
      end
   end

   assign bus_rdata = st.rdata;
   assign irq_req   = st.irq_req;
   assign irq_src   = st.irq_src;
   assign irq_level = st.irq_level;
   assign txd       = st.txd;

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_fire;
      push && st.armed && (st.since == ALARM_LEVEL - 5'h1);
   endsequence

   sequence s_halted;
      (st.scan == SCAN_HALT) && !tx_wr && st.tx_en[st.line] && st.scan_en;
   endsequence

   chk_alarm_fire: assert property (s_fire |=> st.alarm && !st.armed)
      else $error("threshold alarm missed");
   chk_alarm_quiet: assert property ((!st.armed && !rearm) |=> !st.armed && !$rose(st.alarm))
      else $error("alarm re-armed without a read");
   chk_alarm_rearm: assert property ((rearm && !alarm_fire) |=> st.armed && !st.alarm)
      else $error("read did not re-arm alarm");
   chk_rxdone_set: assert property ((head_event && st.rx_ie && !st.alarm_mode) |=> st.rx_pend)
      else $error("receive done event lost");
   chk_rxdone_mute: assert property ((st.alarm_mode && !st.rx_pend && !alarm_fire) |=> !st.rx_pend)
      else $error("receive done raised in alarm mode");
   chk_tx_ready: assert property ((halt_entry && st.tx_ie) |=> st.tx_pend ##0 st.irq_req)
      else $error("transmit ready event lost");
   chk_tx_halt: assert property (s_halted |=> (st.scan == SCAN_HALT) && (st.line == $past(st.line)))
      else $error("scanner left a ready line");
   chk_irq_hold: assert property ((st.irq_req && !irq_ack) |=> st.irq_req)
      else $error("request dropped before acknowledge");
   chk_level_range: assert property (st.irq_level >= 3'h4)
      else $error("interrupt level out of range");
   chk_scan_step: assert property ((st.scan == SCAN_RUN && st.scan_en && osc_tick && st.phase == PHASE_STEP)
                                   |=> st.line == $past(st.line) + 3'h1)
      else $error("scanner did not advance");
   chk_fifo_depth: assert property (st.cnt <= 7'(FIFO_DEPTH))
      else $error("queue count past depth");

endmodule // multi_line_async_serial_mux

//--- serial_mux_pkg.sv
// serial_mux_pkg: sizes, register map, field positions, reset values and timing for the line multiplexer
// assumes one core clock domain; counts derived from the core rate are worked out in the modules
package serial_mux_pkg;

   // ==========================================================
   // sizes
   localparam int LINES      = 8;
   localparam int LINE_W     = 3;
   localparam int FIFO_DEPTH = 64;
   localparam int FIFO_AW    = 6;
   localparam int ENTRY_W    = 13;

   // ==========================================================
   // timing
   localparam int unsigned CORE_CLK_HZ    = 100_000_000;
   localparam int unsigned OSC_HZ         = 5_068_000;
   localparam int unsigned OS_RATE        = 16;
   localparam logic [7:0]  TICK_BIT       = 8'h10;
   localparam logic [3:0]  TICK_MID       = 4'h8;
   localparam logic [7:0]  TICK_STOP_HALF = 8'h18;
   localparam logic [7:0]  TICK_STOP_TWO  = 8'h20;
   localparam logic [4:0]  ALARM_LEVEL    = 5'h10;
   localparam logic [1:0]  PHASE_RX       = 2'h1;
   localparam logic [1:0]  PHASE_TX       = 2'h2;
   localparam logic [1:0]  PHASE_STEP     = 2'h3;
   // line rates in tenths of a baud; the last slot repeats the top rate
   localparam int unsigned BAUD_X10 [16] = '{500, 750, 1100, 1345, 1500, 3000, 6000, 12000,
                                            18000, 20000, 24000, 36000, 48000, 72000, 96000, 96000};

   // ==========================================================
   // register map (word index on the low address bits)
   localparam logic [1:0] ADDR_CTRL   = 2'h0;
   localparam logic [1:0] ADDR_RXBUF  = 2'h1;
   localparam logic [1:0] ADDR_TXCTRL = 2'h2;
   localparam logic [1:0] ADDR_MODEM  = 2'h3;

   localparam int CTRL_SCAN_EN    = 5;
   localparam int CTRL_RX_IE      = 6;
   localparam int CTRL_ALARM_MODE = 12;
   localparam int CTRL_TX_IE      = 14;
   localparam int PRM_LINE_LO     = 0;
   localparam int PRM_LEN_LO      = 3;
   localparam int PRM_STOP_LO     = 5;
   localparam int PRM_RATE_LO     = 8;
   localparam int PRM_RX_EN       = 12;

   localparam logic [1:0] LEN_RESET  = 2'h3;
   localparam logic [3:0] RATE_RESET = 4'he;
   localparam logic [1:0] STOP_ONE   = 2'h0;
   localparam logic [1:0] STOP_TWO   = 2'h1;
   localparam logic [1:0] STOP_HALF  = 2'h2;

   // ==========================================================
   // interrupt
   localparam logic       SRC_RX = 1'b0;
   localparam logic       SRC_TX = 1'b1;
   localparam logic [2:0] LEVEL_DEFAULT = 3'h5;
   localparam logic [2:0] LEVEL_BY_SEL [4] = '{3'h5, 3'h4, 3'h6, 3'h7};

   typedef enum logic [2:0] {
      SCAN_IDLE = 3'b001,
      SCAN_RUN  = 3'b010,
      SCAN_HALT = 3'b100
   } scan_state_t;

endpackage

//--- rx_fifo_store.sv
// rx_fifo_store: 64-entry storage for the shared receive queue, registered read port
// assumes pointers are kept by the owner; a write to the address being read is passed through
`timescale 1ns/1ps
module rx_fifo_store
   import serial_mux_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               wr_en,
   input  wire logic [FIFO_AW-1:0] wr_addr,
   input  wire logic [ENTRY_W-1:0] wr_data,
   input  wire logic [FIFO_AW-1:0] rd_addr,
   output      logic [ENTRY_W-1:0] rd_data
);

   // ==========================================================
   // storage
   logic [ENTRY_W-1:0] mem [FIFO_DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // bypass keeps the head current when a char lands in an empty queue
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data <= '0;
      end else if (wr_en && (wr_addr == rd_addr)) begin
         rd_data <= wr_data;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule // rx_fifo_store

//--- serial_line_source.sv
// serial_line_source: terminal side model, sends async frames onto the receive lines
// assumes 8 data bits, one stop bit, bit time counted in core clock cycles
`timescale 1ns/1ps
module serial_line_source #(
   parameter int bit_cycles = 1666
) (
   input  wire logic       core_clk,
   output      logic [7:0] rxd
);
   // idle lines rest at mark, as a terminal's line does
   initial rxd = 8'hff;
   // ==========================================================
   // frame sender
   // start bit, low bit first, one stop bit; masked lines send together
   task automatic send(input logic [7:0] lines, input logic [7:0] ch);
      logic [9:0] frame;
      frame = {1'b1, ch, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= frame[i] ? 8'hff : ~lines;
         repeat (bit_cycles) @(posedge core_clk);
      end
   endtask
endmodule // serial_line_source

//--- multi_line_async_serial_mux_tb.sv
// multi_line_async_serial_mux_tb: register-port bench with a terminal model on the receive lines
// assumes core_hz shrunk to 16 MHz so one 9600 baud bit is about 1666 cycles
`timescale 1ns/1ps
module multi_line_async_serial_mux_tb;
   import serial_mux_pkg::*;
   localparam int BITC = 1666;
   logic core_clk, rst, bus_wr, bus_rd, irq_ack, irq_req, irq_src;
   logic [5:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata, d;
   logic [1:0] bus_bytes, level_switch;
   logic [2:0] irq_level;
   logic [7:0] rxd, txd, carrier, ring;
   logic [2:0] lvl_tab [4] = '{3'h5, 3'h4, 3'h6, 3'h7};
   int bad_count, checked, n;
   multi_line_async_serial_mux #(.core_hz(16000000)) i_multi_line_async_serial_mux (.core_clk(core_clk),
      .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_bytes(bus_bytes), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata), .base_switch(4'h9), .level_switch(level_switch),
      .irq_ack(irq_ack), .irq_req(irq_req), .irq_src(irq_src), .irq_level(irq_level), .rxd(rxd),
      .txd(txd), .carrier(carrier), .ring(ring));
   serial_line_source #(.bit_cycles(BITC)) i_serial_line_source (.core_clk(core_clk), .rxd(rxd));
   // ==========================================================
   // helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("checked %0d, bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [1:0] idx, input logic [15:0] v, input logic [1:0] lanes);
      @(posedge core_clk);
      bus_addr <= {4'h9, idx};
      bus_wdata <= v;
      bus_bytes <= lanes;
      bus_wr <= 1'b1;
      @(posedge core_clk);
      bus_wr <= 1'b0;
   endtask
   // the answer stands only in the cycle after the strobe
   task automatic rd(input logic [5:0] a, output logic [15:0] v);
      @(posedge core_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge core_clk);
      bus_rd <= 1'b0;
      #1 v = bus_rdata;
   endtask
   task automatic wait_irq();
      n = 0;
      while (irq_req !== 1'b1) begin
         @(posedge core_clk);
         if (++n > 40000) begin
            bad_count++;
            final_report();
         end
      end
   endtask
   task automatic ack();
      @(posedge core_clk);
      irq_ack <= 1'b1;
      @(posedge core_clk);
      irq_ack <= 1'b0;
      #1 check(irq_req, 1'b0);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      core_clk = 0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      rst = 1; bus_wr = 0; bus_rd = 0; irq_ack = 0; bus_addr = 0; bus_wdata = 0;
      bus_bytes = 0; level_switch = 0; carrier = 0; ring = 0;
      repeat (12) @(posedge core_clk);
      rst <= 0;
      repeat (3) @(posedge core_clk);
      check(irq_level, 3'h5);
      check(txd, 8'hff);
      for (int i = 0; i < 4; i++) begin
         level_switch <= 2'(i);
         repeat (5) @(posedge core_clk);
         check(irq_level, lvl_tab[i]);
      end
      // a foreign base must stay silent even on a read
      rd({4'h3, ADDR_CTRL}, d);
      check(d, 16'h0000);
      wr(ADDR_CTRL, 16'h0060, 2'h3);
      wr(ADDR_RXBUF, 16'h1e1b, 2'h3);
      carrier <= 8'h5a;
      ring <= 8'h81;
      repeat (5) @(posedge core_clk);
      rd({4'h9, ADDR_MODEM}, d);
      check(d, 16'h5a81);
      check(irq_req, 1'b0);
      i_serial_line_source.send(8'h08, 8'ha5);
      wait_irq();
      check(irq_src, 1'b0);
      ack();
      rd({4'h9, ADDR_RXBUF}, d);
      check(d, 16'h83a5);
      rd({4'h9, ADDR_RXBUF}, d);
      check(d[15], 1'b0);
      // sixteen chars in alarm mode: eight lines, two frames each
      wr(ADDR_CTRL, 16'h1060, 2'h3);
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_RXBUF, 16'h1e18 | 16'(i), 2'h3);
      end
      i_serial_line_source.send(8'hff, 8'h5a);
      check(irq_req, 1'b0);
      i_serial_line_source.send(8'hff, 8'h5a);
      wait_irq();
      check(irq_src, 1'b0);
      ack();
      rd({4'h9, ADDR_CTRL}, d);
      check(d & 16'h2080, 16'h2080);
      rd({4'h9, ADDR_RXBUF}, d);
      check(d & 16'h80ff, 16'h805a);
      rd({4'h9, ADDR_CTRL}, d);
      check(d & 16'h2000, 16'h0000);
      wr(ADDR_CTRL, 16'h4060, 2'h3);
      wr(ADDR_TXCTRL, 16'h0002, 2'h3);
      wait_irq();
      check(irq_src, 1'b1);
      rd({4'h9, ADDR_CTRL}, d);
      // fifteen chars are still queued from the alarm run
      check(d & 16'h8780, 16'h8180);
      ack();
      wr(ADDR_MODEM, 16'h003c, 2'h1);
      n = 0;
      while (txd[1] !== 1'b0 && n < 4 * BITC) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 4 * BITC) begin
         bad_count++;
         final_report();
      end
      repeat (BITC / 2) @(posedge core_clk);
      for (int i = 0; i < 10; i++) begin
         d[i] = txd[1];
         repeat (BITC) @(posedge core_clk);
      end
      check(d[9:0], {1'b1, 8'h3c, 1'b0});
      final_report();
   end
endmodule // multi_line_async_serial_mux_tb
